// [src/rst_seq_pkg.sv]
package rst_seq_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned EXT_RESET_MIN_US = 200;
    localparam int unsigned POR_MIN_MS = 20;
    localparam int unsigned POR_TYP_MS = 40;
    localparam int unsigned POR_MAX_MS = 100;
    localparam int unsigned EXT_RESET_CYCLES = EXT_RESET_MIN_US * CLK_MHZ;
    localparam int unsigned POR_TYP_CYCLES = POR_TYP_MS * 1000 * CLK_MHZ;
    localparam int unsigned POR_MIN_CYCLES = POR_MIN_MS * 1000 * CLK_MHZ;
    localparam int unsigned POR_MAX_CYCLES = POR_MAX_MS * 1000 * CLK_MHZ;
    localparam int unsigned INIT_TYP_CYCLES = 1000;
    localparam int CNT_W = 32;

    // ------------------------------------------------------------
    // command codes on the command port
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_ATTENTION = 3'h1,
        CMD_SET_CLOCK = 3'h2,
        CMD_SET_ALARM = 3'h3,
        CMD_POWER_OFF = 3'h4,
        CMD_STATUS_EN = 3'h5
    } cmd_e;

    typedef enum logic [1:0] {
        RSP_NONE = 2'h0,
        RSP_OK = 2'h1,
        RSP_READY = 2'h2,
        RSP_ERROR = 2'h3
    } rsp_e;

    function automatic logic [CNT_W-1:0] satInc(input logic [CNT_W-1:0] v);
        satInc = (v == {CNT_W{1'b1}}) ? v : v + 32'h1;
    endfunction : satInc

endpackage : rst_seq_pkg

// [src/rst_link_if.sv]
`timescale 1ns/10ps
interface rst_link_if;
    logic devRstOut;
    logic devRstOe;
    logic hostRstOut;
    logic hostRstOe;
    logic rstLineIn;
    logic onOffLow;
    logic cmdValid;
    logic [2:0] cmdCode;
    logic [31:0] cmdData;
    logic cts;
    logic rspValid;
    logic [1:0] rspCode;

    // open-drain wired line with internal pull-up
    assign rstLineIn = !((devRstOe && !devRstOut) ||
                         (hostRstOe && !hostRstOut));

    modport device (output devRstOut, output devRstOe, input rstLineIn,
                    input onOffLow, input cmdValid, input cmdCode,
                    input cmdData, output cts, output rspValid,
                    output rspCode);
    modport host (output hostRstOut, output hostRstOe, input rstLineIn,
                  output onOffLow, output cmdValid, output cmdCode,
                  output cmdData, input cts, input rspValid,
                  input rspCode);
endinterface : rst_link_if

// [src/rst_seq_device.sv]
`timescale 1ns/10ps
// Notes on behaviour
// - host holds reset low at least 200us
// - stay reset while line low
// - power-up drives line low 20-100ms
// - external and internal resets treated alike
// - reset line bidirectional, device may drive
// - host drives line open-drain only
// - unused reset left open, pull-up
// - host prefers software reset
// - attention answered OK after init
// - flow control holds early commands
// - host may enable readiness report
// - host sets clock before alarm off
// - set alarm, ground on/off, stay on
// - power-off with pin low: off till alarm
// - low power until alarm, self wake
module rst_seq_device
    import rst_seq_pkg::*;
#(
    parameter int unsigned POR_CYCLES = POR_TYP_CYCLES,
    parameter int unsigned INIT_CYCLES = INIT_TYP_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    rst_link_if.device link,
    input wire logic [31:0] timeNow,
    output logic powered,
    output logic inReset,
    output logic alarmArmed
);

    typedef enum logic [4:0] {
        S_POR = 5'b00001,
        S_RESET = 5'b00010,
        S_INIT = 5'b00100,
        S_RUN = 5'b01000,
        S_OFF = 5'b10000
    } state_e;

    // ------------------------------------------------------------
    // reset line sampling
    // ------------------------------------------------------------
    logic sync1_q, sync2_q;
    logic [CNT_W-1:0] lowCnt_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end else begin
            sync1_q <= link.rstLineIn;
            sync2_q <= sync1_q;
        end
    end

    // only a low held for the full minimum counts; glitches are ignored
    wire logic lineLow = !sync2_q;
    wire logic extValid = lowCnt_q >= CNT_W'(EXT_RESET_CYCLES);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) lowCnt_q <= '0;
        else lowCnt_q <= lineLow ? satInc(lowCnt_q) : '0;
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    state_e state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [31:0] alarm_q;
    logic alarmSet_q, clockSet_q, statusEn_q;
    logic drive_q, cts_q, rspValid_q;
    logic [1:0] rspCode_q;

    // command code match, shared by every decode below
    function automatic logic cmdIs(input logic [2:0] code, input cmd_e which);
        cmdIs = code == which;
    endfunction : cmdIs

    wire logic porDone = cnt_q >= CNT_W'(POR_CYCLES - 1);
    wire logic initDone = cnt_q >= CNT_W'(INIT_CYCLES - 1);
    wire logic running = state_q == S_RUN;
    wire logic cmdTake = running && link.cmdValid;
    wire logic isAtt = cmdTake && cmdIs(link.cmdCode, CMD_ATTENTION);
    wire logic isClk = cmdTake && cmdIs(link.cmdCode, CMD_SET_CLOCK);
    wire logic isAlm = cmdTake && cmdIs(link.cmdCode, CMD_SET_ALARM);
    wire logic isOff = cmdTake && cmdIs(link.cmdCode, CMD_POWER_OFF);
    wire logic isSt = cmdTake && cmdIs(link.cmdCode, CMD_STATUS_EN);
    // off is refused unless the pin is grounded, the alarm time is stored and the clock has been set
    wire logic offReady = link.onOffLow && alarmSet_q && clockSet_q;
    wire logic offOk = isOff && offReady;
    wire logic alarmHit = alarmSet_q && timeNow >= alarm_q;

    always_comb begin
        state_d = state_q;
        cnt_d = satInc(cnt_q);
        case (state_q)
            S_POR: begin
                if (porDone) begin
                    state_d = S_RESET;
                    cnt_d = '0;
                end
            end
            S_RESET: begin
                if (!lineLow) begin
                    state_d = S_INIT;
                    cnt_d = '0;
                end
            end
            S_INIT: begin
                if (initDone) state_d = S_RUN;
            end
            S_RUN: begin
                if (offOk) state_d = S_OFF;
            end
            S_OFF: begin
                if (alarmHit) begin
                    state_d = S_INIT;
                    cnt_d = '0;
                end
            end
            default: state_d = S_POR;
        endcase
        // power-up reset is never cut short by an early external low
        // either source lands in the same reset state
        if (state_q != S_POR && extValid) begin
            state_d = S_RESET;
            cnt_d = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= S_POR;
            cnt_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // ------------------------------------------------------------
    // command handling
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alarm_q <= 32'h0;
            alarmSet_q <= 1'b0;
            clockSet_q <= 1'b0;
            statusEn_q <= 1'b0;
        end else begin
            if (isClk) begin
                clockSet_q <= 1'b1;
            end
            if (isAlm) begin
                alarm_q <= link.cmdData;
                alarmSet_q <= 1'b1;
            end
            if (isSt) statusEn_q <= link.cmdData[0];
            // alarm is consumed by the wake-up
            if (state_q == S_OFF && alarmHit) alarmSet_q <= 1'b0;
        end
    end

    // ready report only in init, answers only in run: they never collide
    wire logic readyEvt = state_q == S_INIT && initDone && statusEn_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rspValid_q <= 1'b0;
            rspCode_q <= RSP_NONE;
        end else begin
            rspValid_q <= cmdTake || readyEvt;
            if (readyEvt) rspCode_q <= RSP_READY;
            else if (isAtt || isClk || isAlm || isSt || offOk)
                rspCode_q <= RSP_OK;
            else if (cmdTake) rspCode_q <= RSP_ERROR;
            else rspCode_q <= RSP_NONE;
        end
    end

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_q <= 1'b1;
            cts_q <= 1'b0;
            powered <= 1'b1;
            inReset <= 1'b1;
            alarmArmed <= 1'b0;
        end else begin
            drive_q <= state_d == S_POR;
            cts_q <= state_d == S_RUN;
            powered <= state_d != S_OFF;
            inReset <= state_d == S_POR || state_d == S_RESET;
            alarmArmed <= alarmSet_q;
        end
    end

    // only ever pulls low; the pull-up supplies the high level
    assign link.devRstOut = 1'b0;
    assign link.devRstOe = drive_q;
    assign link.cts = cts_q;
    assign link.rspValid = rspValid_q;
    assign link.rspCode = rspCode_q;

endmodule : rst_seq_device

// [src/rst_seq_host.sv]
`timescale 1ns/10ps
module rst_seq_host
    import rst_seq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    rst_link_if.host link,
    input wire logic hwResetReq,
    input wire logic reqValid,
    input wire logic [2:0] reqCode,
    input wire logic [31:0] reqData,
    input wire logic onOffGround,
    output logic reqReady,
    output logic ansValid,
    output logic [1:0] ansCode,
    output logic lineHigh
);

    // ------------------------------------------------------------
    // emergency reset pulse
    // ------------------------------------------------------------
    logic [CNT_W-1:0] pulse_q;
    logic pull_q, valid_q, ready_q;
    logic [2:0] code_q;
    logic [31:0] data_q;
    logic onOff_q;

    // pulse only, hardware reset reserved for emergencies
    wire logic pulseBusy = pulse_q != '0;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_q <= '0;
            pull_q <= 1'b0;
        end else begin
            if (hwResetReq && !pulseBusy)
                pulse_q <= CNT_W'(EXT_RESET_CYCLES + 2);
            else if (pulseBusy)
                pulse_q <= pulse_q - 32'h1;
            pull_q <= (hwResetReq && !pulseBusy) || pulse_q > 32'h1;
        end
    end

    // ------------------------------------------------------------
    // commands, held until the device clears to send
    // ------------------------------------------------------------
    wire logic sent = valid_q && link.cts;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            valid_q <= 1'b0;
            code_q <= 3'h0;
            data_q <= 32'h0;
            ready_q <= 1'b0;
            onOff_q <= 1'b0;
            ansValid <= 1'b0;
            ansCode <= RSP_NONE;
            lineHigh <= 1'b1;
        end else begin
            if (reqValid && ready_q) begin
                valid_q <= 1'b1;
                code_q <= reqCode;
                data_q <= reqData;
            end else if (sent) begin
                valid_q <= 1'b0;
            end
            ready_q <= !valid_q && !(reqValid && ready_q);
            onOff_q <= onOffGround;
            ansValid <= link.rspValid;
            ansCode <= link.rspCode;
            lineHigh <= link.rstLineIn;
        end
    end

    assign reqReady = ready_q;
    // never drives high, only pulls low
    assign link.hostRstOut = 1'b0;
    assign link.hostRstOe = pull_q;
    assign link.cmdValid = sent;
    assign link.cmdCode = code_q;
    assign link.cmdData = data_q;
    assign link.onOffLow = onOff_q;

endmodule : rst_seq_host

// [verif/rst_seq_monitor.sv]
`timescale 1ns/10ps
module rst_seq_monitor
    import rst_seq_pkg::*;
#(
    parameter int unsigned POR_CYCLES = 50,
    parameter int unsigned INIT_CYCLES = 10
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic devRstOut,
    input wire logic devRstOe,
    input wire logic hostRstOut,
    input wire logic hostRstOe,
    input wire logic rstLineIn,
    input wire logic cmdValid,
    input wire logic [2:0] cmdCode,
    input wire logic cts,
    input wire logic rspValid,
    input wire logic [1:0] rspCode
);
    // ------------------------------------------------
    // line counters, por count frozen to avoid wrap
    // ------------------------------------------------
    logic [31:0] porCnt_q, lowCnt_q, highCnt_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            porCnt_q <= 32'h0;
            lowCnt_q <= 32'h0;
            highCnt_q <= 32'h0;
        end else begin
            porCnt_q <= porCnt_q + {31'h0, porCnt_q < POR_CYCLES + 16};
            lowCnt_q <= rstLineIn ? 32'h0 : lowCnt_q + 32'h1;
            highCnt_q <= rstLineIn ? highCnt_q + 32'h1 : 32'h0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_held_low_reset: assert property (
        lowCnt_q >= EXT_RESET_CYCLES + 2 |=> !cts)
        else $error("ready while line held low");
    a_ready_after_init: assert property (
        $rose(cts) |-> highCnt_q >= INIT_CYCLES)
        else $error("ready too early");
    a_por_line_low: assert property (
        porCnt_q < POR_CYCLES - 1 |-> !rstLineIn)
        else $error("power-up low too short");
    a_por_release: assert property (
        porCnt_q == POR_CYCLES + 8 |-> !devRstOe)
        else $error("line not released");
    a_attention_ok: assert property (
        cmdValid && cts && cmdCode == CMD_ATTENTION
        |=> rspValid && rspCode == RSP_OK)
        else $error("attention not answered OK");
    a_unknown_error: assert property (
        cmdValid && cts && cmdCode > 3'h5
        |=> rspValid && rspCode == RSP_ERROR)
        else $error("unknown code not refused");
    a_flow_hold: assert property (
        !cts |=> !rspValid || rspCode == RSP_READY)
        else $error("answer while not ready");
    a_dev_open_drain: assert property (
        devRstOe |-> !devRstOut && !rstLineIn)
        else $error("device drives line high");
    a_host_open_drain: assert property (
        hostRstOe |-> !hostRstOut && !rstLineIn)
        else $error("host drives line high");
    cover property (cmdValid && cmdCode == CMD_ATTENTION);
    cover property (rspValid && rspCode == RSP_READY);
    cover property (lowCnt_q == EXT_RESET_CYCLES);
endmodule : rst_seq_monitor

// [verif/test_reset_and_alarm_power_seq.sv]
`timescale 1ns/10ps
module test_reset_and_alarm_power_seq;
    import rst_seq_pkg::*;
    localparam int unsigned POR = 50;
    localparam int unsigned INIT = 10;
    logic clk, rst_n, hwResetReq, reqValid, onOffGround, reqReady;
    logic ansValid, powered, inReset, alarmArmed, lineHigh;
    logic [2:0] reqCode;
    logic [31:0] reqData, timeNow;
    logic [1:0] ansCode, ans;
    int n_fail = 0;
    int n_compared = 0;
    int k;
    rst_link_if link ();
    rst_seq_device #(.POR_CYCLES(POR), .INIT_CYCLES(INIT)) i_rst_seq_device (
        .clk(clk), .rst_n(rst_n), .link(link), .timeNow(timeNow),
        .powered(powered), .inReset(inReset), .alarmArmed(alarmArmed));
    rst_seq_host i_rst_seq_host (.clk(clk), .rst_n(rst_n), .link(link),
        .hwResetReq(hwResetReq), .reqValid(reqValid), .reqCode(reqCode),
        .reqData(reqData), .onOffGround(onOffGround), .reqReady(reqReady),
        .ansValid(ansValid), .ansCode(ansCode), .lineHigh(lineHigh));
    rst_seq_monitor #(.POR_CYCLES(POR), .INIT_CYCLES(INIT)) i_rst_seq_monitor (
        .clk(clk), .rst_n(rst_n), .devRstOut(link.devRstOut),
        .devRstOe(link.devRstOe), .hostRstOut(link.hostRstOut),
        .hostRstOe(link.hostRstOe), .rstLineIn(link.rstLineIn),
        .cmdValid(link.cmdValid), .cmdCode(link.cmdCode), .cts(link.cts),
        .rspValid(link.rspValid), .rspCode(link.rspCode));
    // ------------------------------------------------
    // shared tasks
    // ------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // held until taken, answer awaited for a bounded time
    task automatic request(input logic [2:0] code, input logic [31:0] data);
        reqCode = code;
        reqData = data;
        reqValid = 1'b1;
        ans = 2'bxx;
        k = 0;
        while (reqReady !== 1'b1 && k < 5000) begin tick(1); k++; end
        tick(1);
        reqValid = 1'b0;
        k = 0;
        while (ansValid !== 1'b1 && k < 100) begin tick(1); k++; end
        ans = ansCode;
    endtask : request
    task automatic results;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results
    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic t_powerup;
        tick(POR - 10);
        check("line in power-up", lineHigh, 0);
        check("reset flag", inReset, 1);
        tick(20);
        check("line released", lineHigh, 1);
        request(CMD_ATTENTION, 0);
        check("attention", ans, RSP_OK);
    endtask : t_powerup
    task automatic t_emergency;
        request(CMD_STATUS_EN, 1);
        check("status enable", ans, RSP_OK);
        hwResetReq = 1'b1;
        tick(1);
        hwResetReq = 1'b0;
        k = 0;
        while (lineHigh !== 1'b0 && k < 20) begin tick(1); k++; end
        k = 0;
        while (lineHigh !== 1'b1 && k < 30000) begin tick(1); k++; end
        check("pulse length", k >= EXT_RESET_CYCLES, 1);
        check("held reset", inReset, 1);
        k = 0;
        while (ansValid !== 1'b1 && k < 500) begin tick(1); k++; end
        check("ready report", ansCode, RSP_READY);
        request(CMD_ATTENTION, 0);
        check("attention", ans, RSP_OK);
    endtask : t_emergency
    task automatic t_alarm;
        request(CMD_POWER_OFF, 0);
        check("off refused", ans, RSP_ERROR);
        request(3'h7, 0);
        check("unknown code", ans, RSP_ERROR);
        timeNow = 32'h10;
        request(CMD_SET_ALARM, 32'h40);
        check("alarm set", ans, RSP_OK);
        check("armed", alarmArmed, 1);
        onOffGround = 1'b1;
        tick(4);
        check("on while grounded", powered, 1);
        request(CMD_POWER_OFF, 0);
        check("off needs clock", ans, RSP_ERROR);
        check("still on", powered, 1);
        request(CMD_SET_CLOCK, 32'h10);
        check("clock set", ans, RSP_OK);
        request(CMD_POWER_OFF, 0);
        check("off accepted", ans, RSP_OK);
        tick(2);
        check("off", powered, 0);
        timeNow = 32'h3f;
        tick(20);
        check("off till alarm", powered, 0);
        timeNow = 32'h40;
        tick(5);
        check("woken", powered, 1);
        check("alarm consumed", alarmArmed, 0);
    endtask : t_alarm
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (50000) @(posedge clk);
        n_fail++;
        results();
    end
    initial begin
        {rst_n, hwResetReq, reqValid, onOffGround} = 4'h0;
        reqCode = 3'h0;
        reqData = 32'h0;
        timeNow = 32'h0;
        repeat (10) @(posedge clk);
        #1 rst_n = 1'b1;
        t_powerup();
        t_emergency();
        t_alarm();
        results();
    end
endmodule : test_reset_and_alarm_power_seq
